// ---- hdl/sar_regs.svh ----
// Purpose: Frame positions and result codes of the serial readout
// Assumes: Falling serial clock edges counted from 1 within a frame
// Notes:   Definitions only
`ifndef SAR_REGS_SVH
`define SAR_REGS_SVH

// Falling-edge positions inside one chip-select-low frame
`define SAR_FALL_NONE   5'h00
`define SAR_FALL_FIRST  5'h01
`define SAR_FALL_LEAD   5'h02
`define SAR_FALL_MSB    5'h03
`define SAR_FALL_PRELST 5'h11
`define SAR_FALL_LAST   5'h12

// Full-scale two's-complement result codes
`define SAR_POS_FS      16'h7fff
`define SAR_NEG_FS      16'h8000

// Reset values of the pin synchroniser (select idles high)
`define SAR_PIN_IDLE    2'h3

`endif

// ---- hdl/sar_pkg.sv ----
// Purpose: Types shared by the serial readout design
// Assumes: Nothing beyond the header of constants
// Notes:   One-hot state codes
package sar_pkg;

    // Frame sequencer states
    typedef enum logic [2:0] {
        SAR_IDLE = 3'h1,   // Select high, tracking at low power
        SAR_CONV = 3'h2,   // Converting and shifting
        SAR_TAIL = 3'h4    // Select still low after the last bit
    } sar_state_t;

endpackage : sar_pkg

// ---- hdl/sar_stream_if.sv ----
// Purpose: Valid/ready word stream between design modules
// Assumes: Producer holds data while valid and not ready
// Notes:   No clocking block
`timescale 1ns/1ps
interface sar_stream_if #(parameter int W = 16);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sar_stream_if

// ---- hdl/sar_sync.sv ----
// Purpose: Two-flop synchroniser for pins from outside the clock domain
// Assumes: Each bit is an independent level
// Notes:   The first stage is read by the second stage only
`timescale 1ns/1ps
module sar_sync #(
    parameter int               W    = 2,
    parameter logic [W-1:0]     INIT = '0
) (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rstN,
    // Levels
    input  wire logic [W-1:0]   d,
    output      logic [W-1:0]   q
);

    logic [W-1:0] meta_r;

    // ************************************************************
    // Two stages
    // ************************************************************
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            meta_r <= INIT;
            q      <= INIT;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : sar_sync

// ---- hdl/sar_fifo.sv ----
// Purpose: Word FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Full and empty from pointers with a wrap bit
`timescale 1ns/1ps
module sar_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rstN,
    // Streams
    sar_stream_if.snk   inS,
    sar_stream_if.src   outS
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW:0]   wrPtr_r;
    logic [AW:0]   rdPtr_r;
    wire           full;
    wire           empty;
    wire           push;
    wire           pop;

    // Status and handshakes
    assign full  = (wrPtr_r[AW] != rdPtr_r[AW]) &&
                   (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
    assign empty = (wrPtr_r == rdPtr_r);
    assign push  = inS.valid && !full;
    assign pop   = outS.ready && !empty;
    assign inS.ready  = !full;
    assign outS.valid = !empty;
    assign outS.data  = mem[rdPtr_r[AW-1:0]];

    // ************************************************************
    // Pointers
    // ************************************************************
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else begin
            if (push) wrPtr_r <= wrPtr_r + (AW+1)'(1);
            if (pop)  rdPtr_r <= rdPtr_r + (AW+1)'(1);
        end
    end

    // Storage
    always_ff @(posedge clk) begin
        if (push) mem[wrPtr_r[AW-1:0]] <= inS.data;
    end

endmodule : sar_fifo

// ---- hdl/sar_serial_readout.sv ----
// Purpose: Conversion and serial readout sequencing of a 16-bit SAR
//          converter behind a select / serial clock / data link
// Assumes: diffIn is the differential input in LSB units, on clk_sys
// Notes:   Link pins are oversampled by clk_sys through two flops
//
// Function
// RULE1 - Capture the differential input when a conversion starts.
// RULE2 - Hold the captured input isolated while converting.
// RULE3 - Return to low-power tracking after each window; restart at once.
// RULE4 - Track at low power when select high or after 18th fall.
// RULE5 - Link is select and serial clock in, result data out.
// RULE6 - Controller gives at least 18 serial clocks per frame.
// RULE7 - Raising select mid-frame abandons the conversion.
// RULE8 - Result shifts out most significant bit first.
// RULE9 - Word shifted is from this frame's conversion, no delay.
// RULE10 - Largest positive input gives code 7FFFh.
// RULE11 - Most negative input gives code 8000h.
// RULE12 - Data floats while select high and for the first period.
// RULE13 - Second falling edge drives a leading zero.
// RULE14 - Falling edges 3 to 18 drive the 16 result bits.
// RULE15 - Select falling with clock low counts as first falling edge.
// RULE16 - Controller captures on rising edges, releases after 18th.
`timescale 1ns/1ps
`include "sar_regs.svh"
module sar_serial_readout #(
    parameter int RES_W      = 16,
    parameter int IN_W       = 18,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    // Serial link
    input  wire logic                   csN,
    input  wire logic                   sclk,
    output      logic                   dout,
    output      logic                   doutOe,
    // Analog front end
    input  wire logic signed [IN_W-1:0] diffIn,
    output      logic                   lowPowerTrack,
    output      logic                   inputIsolated,
    // Completed result stream
    output      logic                   resValid,
    input  wire logic                   resReady,
    output      logic [RES_W-1:0]       resData,
    output      logic                   resInReady
);

    // ************************************************************
    // Full-scale limits at input width
    // ************************************************************
    localparam logic signed [IN_W-1:0] POS_EXT =
        {{(IN_W-RES_W){1'b0}}, `SAR_POS_FS};
    localparam logic signed [IN_W-1:0] NEG_EXT =
        {{(IN_W-RES_W){1'b1}}, `SAR_NEG_FS};

    // Saturating conversion of the input to a result code
    function automatic logic [RES_W-1:0] clampCode(
        input logic signed [IN_W-1:0] v);
        logic [RES_W-1:0] c;
        c = v[RES_W-1:0];
        if (v >= POS_EXT) c = `SAR_POS_FS;           // RULE10
        else if (v <= NEG_EXT) c = `SAR_NEG_FS;      // RULE11
        return c;
    endfunction : clampCode

    // ************************************************************
    // Reset release
    // ************************************************************
    logic rstMeta_r;
    logic rstSync_r;

    // Asynchronous assert, two-flop release
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    wire rstSyncN = rstSync_r;

    // ************************************************************
    // Pin sampling and edge detection
    // ************************************************************
    logic [1:0] pinSync;
    logic       csPrev_r;
    logic       sclkPrev_r;
    wire        csS;
    wire        sclkS;
    wire        csFall;
    wire        csRise;
    wire        sclkFall;

    sar_sync #(
        .W    (2),
        .INIT (`SAR_PIN_IDLE)
    ) u_pinSync (
        .clk  (clk_sys),
        .rstN (rstSyncN),
        .d    ({csN, sclk}),                                   // RULE5
        .q    (pinSync)
    );

    // Synchronised levels and their edges
    assign csS      = pinSync[1];
    assign sclkS    = pinSync[0];
    assign csFall   = csPrev_r & ~csS;
    assign csRise   = ~csPrev_r & csS;
    assign sclkFall = sclkPrev_r & ~sclkS;

    // Previous samples, idle high so reset gives no false edge
    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            csPrev_r   <= 1'b1;
            sclkPrev_r <= 1'b1;
        end else begin
            csPrev_r   <= csS;
            sclkPrev_r <= sclkS;
        end
    end

    // ************************************************************
    // Frame sequencer
    // ************************************************************
    sar_pkg::sar_state_t state_r;
    sar_pkg::sar_state_t state_nxt;
    logic [4:0]          fallCnt_r;
    logic [4:0]          fallCnt_nxt;
    wire  [4:0]          cntInc;
    wire                 inConv;
    wire                 inTail;

    assign cntInc = fallCnt_r + 5'h01;
    assign inConv = (state_r == sar_pkg::SAR_CONV);
    assign inTail = (state_r == sar_pkg::SAR_TAIL);

    // Next state from select and serial clock falling edges
    always_comb begin
        state_nxt   = state_r;
        fallCnt_nxt = fallCnt_r;
        if (csS) begin
            state_nxt   = sar_pkg::SAR_IDLE;                   // RULE4 RULE7
            fallCnt_nxt = `SAR_FALL_NONE;
        end else if (csFall) begin
            state_nxt   = sar_pkg::SAR_CONV;                   // RULE3
            fallCnt_nxt = sclkS ? `SAR_FALL_NONE
                                : `SAR_FALL_FIRST;             // RULE15
        end else if (sclkFall) begin
            unique case (state_r)
                sar_pkg::SAR_IDLE: begin
                    state_nxt = sar_pkg::SAR_IDLE;
                end
                sar_pkg::SAR_CONV: begin
                    fallCnt_nxt = cntInc;
                    if (cntInc == `SAR_FALL_LAST) begin
                        state_nxt = sar_pkg::SAR_TAIL;         // RULE4
                    end
                end
                sar_pkg::SAR_TAIL: begin
                    state_nxt = sar_pkg::SAR_TAIL;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state_r   <= sar_pkg::SAR_IDLE;
            fallCnt_r <= `SAR_FALL_NONE;
        end else begin
            state_r   <= state_nxt;
            fallCnt_r <= fallCnt_nxt;
        end
    end

    // Power and input-switch status
    assign lowPowerTrack = !inConv;                            // RULE4
    assign inputIsolated = inConv;                             // RULE2

    // ************************************************************
    // Sampling
    // ************************************************************
    logic [RES_W-1:0] sample_r;

    // Capture on select fall, then hold through the conversion
    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            sample_r <= '0;
        end else if (csFall) begin
            sample_r <= clampCode(diffIn);                     // RULE1 RULE9
        end
    end

    // ************************************************************
    // Serial output
    // ************************************************************
    wire       driveFall;
    wire       driveNow;
    wire       inWord;
    wire [4:0] bitIdx;
    wire       doutBit;

    // Falling edge inside a live frame, not the select edge itself
    assign driveFall = sclkFall & ~csS & ~csFall & (inConv | inTail);
    assign driveNow  = driveFall & (inTail | (cntInc >= `SAR_FALL_LEAD));
    assign inWord    = inConv & (cntInc >= `SAR_FALL_MSB);
    assign bitIdx    = `SAR_FALL_LAST - cntInc;
    // Zero on edge 2 and after the last bit, else MSB first
    assign doutBit   = inWord ? sample_r[bitIdx[3:0]] : 1'b0; // RULE8 RULE14

    // Data pin and its enable
    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            dout   <= 1'b0;
            doutOe <= 1'b0;
        end else if (csS || csFall) begin
            dout   <= 1'b0;
            doutOe <= 1'b0;                                    // RULE12
        end else if (driveNow) begin
            dout   <= doutBit;                                 // RULE13 RULE14
            doutOe <= 1'b1;
        end
    end

    // ************************************************************
    // Completed result buffer
    // ************************************************************
    sar_stream_if #(.W(RES_W)) pushIf ();
    sar_stream_if #(.W(RES_W)) popIf ();

    // Push the word once its last bit goes out
    assign pushIf.valid = driveFall & inConv & (cntInc == `SAR_FALL_LAST);
    assign pushIf.data  = sample_r;
    assign resInReady   = pushIf.ready;
    assign resValid     = popIf.valid;
    assign resData      = popIf.data;
    assign popIf.ready  = resReady;

    sar_fifo #(
        .W     (RES_W),
        .DEPTH (FIFO_DEPTH)
    ) u_resFifo (
        .clk   (clk_sys),
        .rstN  (rstSyncN),
        .inS   (pushIf),
        .outS  (popIf)
    );

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cbSys @(posedge clk_sys);
    endclocking
    default disable iff (!rstSyncN);

    a_capture_start: assert property (
        csFall |=> sample_r == clampCode($past(diffIn))) // RULE1
        else $error("Input not captured at frame start");

    a_hold_isolated: assert property (
        inConv && !csFall |=> $stable(sample_r)) // RULE2
        else $error("Sample changed during conversion");

    a_enter_track: assert property (
        driveFall && inConv && fallCnt_r == `SAR_FALL_PRELST
        |=> inTail && lowPowerTrack) // RULE3
        else $error("No tracking after the last falling edge");

    a_select_track: assert property (
        csS |=> state_r == sar_pkg::SAR_IDLE && lowPowerTrack) // RULE4
        else $error("Not tracking while select high");

    a_abort_frame: assert property (
        csRise |=> !doutOe ##1 !doutOe && !inConv) // RULE7
        else $error("Frame not abandoned on select rise");

    a_float_first: assert property (
        csFall |=> !doutOe) // RULE12
        else $error("Data driven in first period");

    a_lead_zero: assert property (
        driveFall && inConv && fallCnt_r == `SAR_FALL_FIRST
        |=> doutOe && !dout) // RULE13
        else $error("Leading zero missing");

    a_msb_first: assert property (
        driveFall && inConv && fallCnt_r == `SAR_FALL_LEAD
        |=> doutOe && dout == sample_r[RES_W-1]) // RULE8
        else $error("MSB not on third falling edge");

    a_lsb_last: assert property (
        driveFall && inConv && fallCnt_r == `SAR_FALL_PRELST
        |-> pushIf.valid ##1 doutOe && dout == sample_r[0]) // RULE14
        else $error("LSB not on eighteenth falling edge");

    a_pos_full: assert property (
        csFall && diffIn >= POS_EXT |=> sample_r == `SAR_POS_FS) // RULE10
        else $error("Positive full scale wrong");

    a_neg_full: assert property (
        csFall && diffIn <= NEG_EXT |=> sample_r == `SAR_NEG_FS) // RULE11
        else $error("Negative full scale wrong");

    a_low_first: assert property (
        csFall && !sclkS |=> fallCnt_r == `SAR_FALL_FIRST) // RULE15
        else $error("Select fall with clock low not counted");

endmodule : sar_serial_readout

// ---- verif/sar_host_model.sv ----
// Purpose: Host controller model, serial bus master of the readout link
// Assumes: Select and serial clock idle high between frames
// Notes:   Low phase 200 ns, high phase 120 ns, a 320 ns period
`timescale 1ns/1ps
module sar_host_model (
    // Link pins
    output logic      csN,
    output logic      sclk,
    input  wire logic dout,
    input  wire logic doutOe
);
    logic      lastLvl;
    wire logic lineLvl;

    // A released data line shows the inverse of its last driven level
    assign lineLvl = doutOe ? dout : ~lastLvl;

    // Remember the last driven level
    always @(dout or doutOe) begin
        if (doutOe === 1'b1) begin
            lastLvl = dout;
        end
    end

    // Idle link
    initial begin
        csN     = 1'b1;
        sclk    = 1'b1;
        lastLvl = 1'b0;
    end

    // One frame of nFall falling edges; data taken on each rising edge
    task automatic frame(input int nFall, input bit lowStart,
                         output logic [17:0] oe, output logic [17:0] bits);
        oe = '0;
        bits = '0;
        #13;
        if (lowStart) begin
            sclk = 1'b0;
            #200;
        end
        csN = 1'b0;
        #120;
        for (int i = 0; i < nFall; i++) begin
            if (!(lowStart && i == 0)) begin
                sclk = 1'b0;
            end
            #200;
            sclk = 1'b1;
            oe[i] = doutOe;
            bits[i] = lineLvl;
            #120;
        end
    endtask : frame

    // End the frame, possibly before the last falling edge
    task automatic end_frame();
        csN = 1'b1;
        sclk = 1'b1;
        #400;
    endtask : end_frame
endmodule : sar_host_model

// ---- verif/tb.sv ----
// Purpose: Self-checking bench of the serial readout block
// Assumes: Host model drives the link, bench drives the rest
// Notes:   Each scenario is a task that judges its own results
`timescale 1ns/1ps
module tb;
    logic               clk_sys;
    logic               rstn;
    logic               resReady;
    logic signed [17:0] diffIn;
    wire logic          csN;
    wire logic          sclk;
    wire logic          dout;
    wire logic          doutOe;
    wire logic          lowPowerTrack;
    wire logic          inputIsolated;
    wire logic          resValid;
    wire logic          resInReady;
    wire logic [15:0]   resData;
    logic [17:0]        oeSeen;
    logic [17:0]        bitSeen;
    int                 fail_count;
    int                 n_checks;

    sar_serial_readout i_dut (.clk_sys(clk_sys), .rstn(rstn), .csN(csN),
        .sclk(sclk), .dout(dout), .doutOe(doutOe), .diffIn(diffIn),
        .lowPowerTrack(lowPowerTrack), .inputIsolated(inputIsolated),
        .resValid(resValid), .resReady(resReady), .resData(resData),
        .resInReady(resInReady));

    sar_host_model i_host (.csN(csN), .sclk(sclk), .dout(dout),
        .doutOe(doutOe));

    // 25 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] expct);
        n_checks++;
        if (seen !== expct) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, expct, seen);
        end
    endtask : check

    // Set the input just after a clock edge
    task automatic set_in(input int v);
        @(posedge clk_sys);
        #1;
        diffIn = 18'(v);
    endtask : set_in

    // Judge the bits captured by the host in the last frame
    task automatic check_bits(input logic [15:0] w, input int nFall);
        check("oe first period", 16'(oeSeen[0]), 16'h0000);
        check("oe second fall", 16'(oeSeen[1]), 16'h0001);
        check("leading zero", 16'(bitSeen[1]), 16'h0000);
        for (int k = 2; k < nFall; k++) begin
            check("result bit", 16'(bitSeen[k]), 16'(w[17-k]));
        end
    endtask : check_bits

    // Take one word from the result stream, bounded wait
    task automatic pop(input logic [15:0] w);
        int n;
        n = 0;
        while (resValid !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 50) begin
            fail_count++;
            close_out();
        end
        check("result word", resData, w);
        resReady = 1'b1;
        @(posedge clk_sys);
        #1;
        resReady = 1'b0;
    endtask : pop

    // Full frame; the input moves while converting
    task automatic t_basic();
        set_in(18'h01234);
        fork
            i_host.frame(18, 1'b0, oeSeen, bitSeen);
            begin
                repeat (40) @(posedge clk_sys);
                #1;
                check("isolated", 16'(inputIsolated), 16'h0001);
                diffIn = 18'sh3edcb;
            end
        join
        check_bits(16'h1234, 18);
        check("tail track", 16'(lowPowerTrack), 16'h0001);
        check("tail connect", 16'(inputIsolated), 16'h0000);
        i_host.end_frame();
        check("idle oe", 16'(doutOe), 16'h0000);
        check("idle connect", 16'(inputIsolated), 16'h0000);
        check("idle track", 16'(lowPowerTrack), 16'h0001);
        pop(16'h1234);
    endtask : t_basic

    // Saturation to the full-scale codes
    task automatic t_codes();
        int          vals[4] = '{40000, 32767, -32768, -40000};
        logic [15:0] exps[4] = '{16'h7fff, 16'h7fff, 16'h8000, 16'h8000};
        for (int i = 0; i < 4; i++) begin
            set_in(vals[i]);
            i_host.frame(18, 1'b0, oeSeen, bitSeen);
            i_host.end_frame();
            check_bits(exps[i], 18);
            pop(exps[i]);
        end
    endtask : t_codes

    // Select falls while the serial clock is low
    task automatic t_lowstart();
        set_in(-2);
        i_host.frame(18, 1'b1, oeSeen, bitSeen);
        i_host.end_frame();
        check_bits(16'hfffe, 18);
        pop(16'hfffe);
    endtask : t_lowstart

    // Short cycle, then an immediate new frame
    task automatic t_abort();
        set_in(18'h00abc);
        i_host.frame(8, 1'b0, oeSeen, bitSeen);
        check_bits(16'h0abc, 8);
        i_host.end_frame();
        check("abort oe", 16'(doutOe), 16'h0000);
        check("abort track", 16'(lowPowerTrack), 16'h0001);
        check("abort no word", 16'(resValid), 16'h0000);
        set_in(18'h00055);
        i_host.frame(18, 1'b0, oeSeen, bitSeen);
        i_host.end_frame();
        check_bits(16'h0055, 18);
        pop(16'h0055);
    endtask : t_abort

    // Fill the result buffer while the reader stalls, then drain it
    task automatic t_fill();
        for (int k = 0; k < 17; k++) begin
            set_in(k * 3 + 1);
            i_host.frame(18, 1'b0, oeSeen, bitSeen);
            i_host.end_frame();
        end
        check("buffer full", 16'(resInReady), 16'h0000);
        for (int k = 0; k < 16; k++) begin
            pop(16'(k * 3 + 1));
        end
        check("buffer empty", 16'(resValid), 16'h0000);
    endtask : t_fill

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        close_out();
    end

    // Main sequence
    initial begin
        fail_count = 0;
        n_checks = 0;
        rstn = 1'b0;
        resReady = 1'b0;
        diffIn = '0;
        repeat (10) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        repeat (8) @(posedge clk_sys);
        t_basic();
        t_codes();
        t_lowstart();
        t_abort();
        t_fill();
        close_out();
    end
endmodule : tb
